// ### usb_bdt_consts.svh
// Offsets, field positions and codes shared by both ends of the USB block.
`ifndef USB_BDT_CONSTS_SVH
`define USB_BDT_CONSTS_SVH

// -----------------------------------------------------------------------------
// Shared USB RAM layout
// -----------------------------------------------------------------------------
`define RAM_DEPTH       256
`define BD_BYTES        8'h03
`define BDT_LAST        8'h1D
`define RSVD_FIRST      8'h1E
`define RSVD_LAST       8'h1F
`define BUF_FIRST       8'h20
`define SLOT_EP0_IN     4'h0
`define SLOT_EP0_OUT    4'h1
`define SLOT_EP5_EVEN   4'h6
`define SLOT_EP6_EVEN   4'h8

// -----------------------------------------------------------------------------
// Descriptor status byte
// -----------------------------------------------------------------------------
`define BD_OWN_BIT      7
`define BD_TOGGLE_BIT   6
`define BD_PID_LSB      2
`define BD_PID_MSB      5
`define BD_STALL_BIT    2

// -----------------------------------------------------------------------------
// Token codes
// -----------------------------------------------------------------------------
`define PID_OUT         4'h1
`define PID_IN          4'h9
`define PID_SETUP       4'hD

// -----------------------------------------------------------------------------
// Controller register map and fields
// -----------------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_RAM_CMD     8'h08
`define REG_RAM_DATA    8'h0C
`define CTRL_RESET      4'h0
`define CTRL_PU_BIT     0
`define CTRL_REGEN_BIT  1
`define CTRL_STOP_LSB   2
`define CMD_WE_BIT      16
`define CMD_BUSY_BIT    8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### usb_bdt_pkg.sv
// Types shared by both ends of the USB descriptor and pull-up block.
package usb_bdt_pkg;

	typedef enum logic [1:0] {
		REG_OFF,
		REG_STANDBY,
		REG_ACTIVE
	} reg_mode_t;

	typedef enum logic [1:0] {
		RUN_MODE,
		SHALLOW_STOP,
		DEEP_STOP_A,
		DEEP_STOP_B
	} stop_mode_t;

	typedef enum logic [1:0] {
		HS_NONE,
		HS_ACK,
		HS_NAK,
		HS_STALL
	} handshake_t;

endpackage : usb_bdt_pkg

// ### usb_bdt_link_if.sv
// Link between the USB engine end and its controller end.
`timescale 1ns/1ps
interface usb_bdt_link_if;
	import usb_bdt_pkg::*;

	logic                ram_req;
	logic                ram_we;
	logic [7:0]          ram_addr;
	logic [7:0]          ram_wdata;
	logic                ram_ack;
	logic [7:0]          ram_rdata;
	logic                internal_pullup_enable;
	logic                regulator_enable;
	stop_mode_t          stop_mode;
	logic                suspend_state;
	reg_mode_t           reg_mode;
	logic                pullup_on;

	modport engine (
		input  ram_req,
		input  ram_we,
		input  ram_addr,
		input  ram_wdata,
		output ram_ack,
		output ram_rdata,
		input  internal_pullup_enable,
		input  regulator_enable,
		input  stop_mode,
		output suspend_state,
		output reg_mode,
		output pullup_on
	);

	modport controller (
		output ram_req,
		output ram_we,
		output ram_addr,
		output ram_wdata,
		input  ram_ack,
		input  ram_rdata,
		output internal_pullup_enable,
		output regulator_enable,
		output stop_mode,
		input  suspend_state,
		input  reg_mode,
		input  pullup_on
	);

endinterface : usb_bdt_link_if

// ### usb_bdt_engine.sv
// USB engine end: shared RAM, descriptor ownership and pull-up control.
//
// Notes on behaviour
// RQ1 - Each descriptor spans three consecutive RAM bytes.
// RQ2 - Table fixed at RAM offsets 0x00 to 0x1D.
// RQ3 - Slots: EP0 IN, EP0 OUT, EP1-4, EP5/EP6 even-odd.
// RQ4 - 0x1E-0x1F reserved; 0x20-0xFF hold endpoint buffers.
// RQ5 - Owner bit zero: processor owns descriptor and buffer.
// RQ6 - Owner bit one: processor leaves descriptor alone.
// RQ7 - Token on enabled endpoint fetches descriptor, checks owner.
// RQ8 - Control endpoint has separate IN and OUT descriptors.
// RQ9 - Double buffering uses even and odd descriptors.
// RQ10 - Regulator active while USB function active.
// RQ11 - Regulator drops to standby during suspend.
// RQ12 - Firmware picks shallow stop when bus suspends.
// RQ13 - Regulator off in deep stops or when disabled.
// RQ14 - Pull-up applied only while bus supply sensed.
// RQ15 - Pull-up enable clear disconnects internal pull-up.
// RQ16 - Bus supply sensing built in for pull-up.
// RQ17 - Self-powered firmware senses supply before enabling.
// RQ18 - Completed token clears owner bit, returns descriptor.
// RQ19 - Processor-owned descriptor: other fields are ignored.
// RQ20 - Processor-owned descriptor answers NAK, stays untouched.
`timescale 1ns/1ps
`include "usb_bdt_consts.svh"

module usb_bdt_engine (
	input  wire logic                    CLK,
	input  wire logic                    RST_B,
	input  wire logic                    TOKEN_VALID,
	input  wire logic [2:0]              TOKEN_EP,
	input  wire logic [3:0]              TOKEN_PID,
	input  wire logic                    TOKEN_ODD,
	input  wire logic [6:0]              EP_ENABLE,
	input  wire logic                    SUSPEND,
	input  wire logic                    VBUS_SENSE,
	output var  logic                    TOKEN_READY,
	output var  logic                    HANDSHAKE_VALID,
	output var  usb_bdt_pkg::handshake_t HANDSHAKE,
	output var  logic                    DPLUS_PULLUP,
	output var  usb_bdt_pkg::reg_mode_t  REG_MODE,
	usb_bdt_link_if.engine               link
);
	import usb_bdt_pkg::*;

	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_FETCH,
		ENG_DECIDE
	} eng_state_t;

	// -------------------------------------------------------------------------
	// Descriptor slot addressing
	// -------------------------------------------------------------------------
	// Maps a token to the first byte of its descriptor; the table layout is
	// fixed, so no software setting moves it.
	function automatic logic [7:0] slot_base(
		input logic [2:0] ep,
		input logic [3:0] pid,
		input logic       odd
	);
		logic [3:0] slot;
		slot = `SLOT_EP0_IN;
		if (ep == 3'h0) begin
			slot = (pid == `PID_IN) ? `SLOT_EP0_IN : `SLOT_EP0_OUT; // RQ8
		end else if (ep == 3'h5) begin
			slot = `SLOT_EP5_EVEN + {3'h0, odd}; // RQ9
		end else if (ep == 3'h6) begin
			slot = `SLOT_EP6_EVEN + {3'h0, odd}; // RQ9
		end else begin
			slot = 4'({1'b0, ep} + 4'h1); // RQ3
		end
		return 8'({4'h0, slot} * `BD_BYTES); // RQ1 RQ2
	endfunction : slot_base

	logic [7:0]  ram [`RAM_DEPTH];
	eng_state_t  state;
	logic [7:0]  bd_addr;
	logic [3:0]  bd_pid;
	logic [7:0]  bd_status;
	logic        vbus_meta;
	logic        vbus_sync;
	logic        token_take;
	logic        eng_write;
	logic        cpu_go;
	logic        cpu_reserved;
	logic [7:0]  next_status;
	reg_mode_t   next_reg_mode;

	// -------------------------------------------------------------------------
	// Token intake and ownership check
	// -------------------------------------------------------------------------
	assign token_take = TOKEN_VALID && TOKEN_READY && TOKEN_EP != 3'h7
		&& EP_ENABLE[TOKEN_EP];

	// The engine writes the status byte back only for a descriptor it owns
	// and that is not stalled.
	assign eng_write = state == ENG_DECIDE && bd_status[`BD_OWN_BIT]
		&& !bd_status[`BD_STALL_BIT];

	always_comb begin
		next_status = bd_status;
		next_status[`BD_OWN_BIT] = 1'b0; // RQ18
		next_status[`BD_PID_MSB:`BD_PID_LSB] = bd_pid;
		next_status[1:0] = 2'h0;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state       <= ENG_IDLE;
			TOKEN_READY <= 1'b0;
			bd_addr     <= 8'h00;
			bd_pid      <= 4'h0;
			bd_status   <= 8'h00;
		end else begin
			unique case (state)
				ENG_IDLE: begin
					TOKEN_READY <= 1'b1;
					if (token_take) begin
						TOKEN_READY <= 1'b0;
						bd_addr     <= slot_base(TOKEN_EP, TOKEN_PID, TOKEN_ODD);
						bd_pid      <= TOKEN_PID;
						state       <= ENG_FETCH; // RQ7
					end
				end
				ENG_FETCH: begin
					bd_status <= ram[bd_addr]; // RQ7
					state     <= ENG_DECIDE;
				end
				ENG_DECIDE: begin
					TOKEN_READY <= 1'b1;
					state       <= ENG_IDLE;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// Handshake answer
	// -------------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			HANDSHAKE_VALID <= 1'b0;
			HANDSHAKE       <= HS_NONE;
		end else begin
			HANDSHAKE_VALID <= 1'b0;
			if (state == ENG_DECIDE) begin
				HANDSHAKE_VALID <= 1'b1;
				if (!bd_status[`BD_OWN_BIT]) begin
					HANDSHAKE <= HS_NAK; // RQ5 RQ19 RQ20
				end else if (bd_status[`BD_STALL_BIT]) begin
					HANDSHAKE <= HS_STALL;
				end else begin
					HANDSHAKE <= HS_ACK;
				end
			end
		end
	end

	// -------------------------------------------------------------------------
	// Shared RAM and processor access
	// -------------------------------------------------------------------------
	// The engine has priority; a processor request waits while the engine
	// writes back a descriptor. The hardware does not block the processor
	// from touching an engine-owned descriptor: firmware must refrain.
	assign cpu_reserved = link.ram_addr == `RSVD_FIRST
		|| link.ram_addr == `RSVD_LAST; // RQ4
	assign cpu_go = link.ram_req && !link.ram_ack && !eng_write; // RQ6

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < `RAM_DEPTH; i++) begin
				ram[i] <= 8'h00;
			end
		end else if (eng_write) begin
			ram[bd_addr] <= next_status; // RQ18
		end else if (cpu_go && link.ram_we && !cpu_reserved) begin
			ram[link.ram_addr] <= link.ram_wdata; // RQ4 RQ5
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			link.ram_ack   <= 1'b0;
			link.ram_rdata <= 8'h00;
		end else begin
			link.ram_ack <= cpu_go;
			if (cpu_go) begin
				link.ram_rdata <= cpu_reserved ? 8'h00 : ram[link.ram_addr];
			end
		end
	end

	// -------------------------------------------------------------------------
	// Bus supply sense, regulator and pull-up
	// -------------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			vbus_meta <= 1'b0;
			vbus_sync <= 1'b0;
		end else begin
			vbus_meta <= VBUS_SENSE; // RQ16
			vbus_sync <= vbus_meta;
		end
	end

	always_comb begin
		if (!link.regulator_enable || link.stop_mode == DEEP_STOP_A
			|| link.stop_mode == DEEP_STOP_B) begin
			next_reg_mode = REG_OFF; // RQ13
		end else if (SUSPEND) begin
			next_reg_mode = REG_STANDBY; // RQ11
		end else begin
			next_reg_mode = REG_ACTIVE; // RQ10
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_MODE           <= REG_OFF;
			DPLUS_PULLUP       <= 1'b0;
			link.reg_mode      <= REG_OFF;
			link.pullup_on     <= 1'b0;
			link.suspend_state <= 1'b0;
		end else begin
			REG_MODE           <= next_reg_mode;
			link.reg_mode      <= next_reg_mode;
			link.suspend_state <= SUSPEND;
			// Without supply sensed or with the enable clear, the line is
			// left for an external pull-up.
			DPLUS_PULLUP   <= link.internal_pullup_enable && vbus_sync
				&& next_reg_mode != REG_OFF; // RQ14 RQ15
			link.pullup_on <= link.internal_pullup_enable && vbus_sync
				&& next_reg_mode != REG_OFF; // RQ14 RQ15
		end
	end

endmodule : usb_bdt_engine

// ### usb_bdt_controller.sv
// Controller end: AXI4-Lite registers that steer the USB engine end.
`timescale 1ns/1ps
`include "usb_bdt_consts.svh"

module usb_bdt_controller (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output var  logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output var  logic        WREADY,
	output var  logic [1:0]  BRESP,
	output var  logic        BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output var  logic        ARREADY,
	output var  logic [31:0] RDATA,
	output var  logic [1:0]  RRESP,
	output var  logic        RVALID,
	input  wire logic        RREADY,
	usb_bdt_link_if.controller link
);
	import usb_bdt_pkg::*;

	logic [7:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	logic        do_write;
	logic [3:0]  ctrl;
	logic [16:0] ram_cmd;
	logic        busy;
	logic [7:0]  ram_data;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	assign do_write = aw_held && w_held && !BVALID;

	// -------------------------------------------------------------------------
	// Write channels
	// -------------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			BVALID  <= 1'b0;
			BRESP   <= `RESP_OKAY;
		end else begin
			AWREADY <= !aw_held && !(AWVALID && AWREADY);
			WREADY  <= !w_held && !(WVALID && WREADY);
			if (AWVALID && AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_held <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end
			if (do_write) begin
				BVALID <= 1'b1;
				BRESP  <= (aw_addr == `REG_CTRL || aw_addr == `REG_RAM_CMD)
					? `RESP_OKAY : `RESP_SLVERR;
			end
			if (BVALID && BREADY) begin
				BVALID  <= 1'b0;
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Control register and RAM access sequencer
	// -------------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl <= `CTRL_RESET;
		end else if (do_write && aw_addr == `REG_CTRL && w_strb[0]) begin
			ctrl <= w_data[3:0]; // RQ15 RQ17
		end
	end

	assign link.internal_pullup_enable = ctrl[`CTRL_PU_BIT];
	assign link.regulator_enable       = ctrl[`CTRL_REGEN_BIT];
	assign link.stop_mode = stop_mode_t'(ctrl[`CTRL_STOP_LSB+:2]); // RQ12

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ram_cmd  <= 17'h0_0000;
			busy     <= 1'b0;
			ram_data <= 8'h00;
		end else begin
			if (do_write && aw_addr == `REG_RAM_CMD && !busy
				&& w_strb[2:0] == 3'h7) begin
				ram_cmd <= w_data[16:0];
				busy    <= 1'b1;
			end
			if (busy && link.ram_ack) begin
				busy     <= 1'b0;
				ram_data <= link.ram_rdata;
			end
		end
	end

	// The request stays high until the engine acknowledges it.
	assign link.ram_req   = busy && !link.ram_ack;
	assign link.ram_we    = ram_cmd[`CMD_WE_BIT];
	assign link.ram_addr  = ram_cmd[7:0];
	assign link.ram_wdata = ram_cmd[15:8];

	// -------------------------------------------------------------------------
	// Read channel
	// -------------------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = `RESP_OKAY;
		unique case (ARADDR)
			`REG_CTRL:     next_rdata = {28'h000_0000, ctrl};
			`REG_STATUS:   next_rdata = {28'h000_0000, link.pullup_on,
				link.suspend_state, link.reg_mode};
			`REG_RAM_CMD:  next_rdata = {15'h0000, ram_cmd};
			`REG_RAM_DATA: next_rdata = {23'h00_0000, busy, ram_data};
			default:       next_rresp = `RESP_SLVERR;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= `RESP_OKAY;
		end else begin
			ARREADY <= !RVALID && !(ARVALID && ARREADY);
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= next_rdata;
				RRESP  <= next_rresp;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

endmodule : usb_bdt_controller

// ### usb_bdt_link_props.sv
// Concurrent checks on the link that joins the engine and controller ends.
`timescale 1ns/1ps
`include "usb_bdt_consts.svh"

module usb_bdt_link_props (
	input wire logic                    CLK,
	input wire logic                    RST_B,
	input wire logic                    ram_req,
	input wire logic                    ram_we,
	input wire logic [7:0]              ram_addr,
	input wire logic [7:0]              ram_wdata,
	input wire logic                    ram_ack,
	input wire logic [7:0]              ram_rdata,
	input wire logic                    internal_pullup_enable,
	input wire logic                    regulator_enable,
	input wire usb_bdt_pkg::stop_mode_t stop_mode,
	input wire logic                    suspend_state,
	input wire usb_bdt_pkg::reg_mode_t  reg_mode,
	input wire logic                    pullup_on
);
	import usb_bdt_pkg::*;

	logic off_cond;

	assign off_cond = !regulator_enable || stop_mode == DEEP_STOP_A ||
		stop_mode == DEEP_STOP_B;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	// ------
	// Shared RAM handshake
	// ------
	a_ack_follows_req: assert property (
		ram_req && !ram_ack |-> ##[1:3] ram_ack)
		else $error("ram request not acknowledged in time");
	a_ack_one_cycle: assert property (
		ram_ack |=> !ram_ack)
		else $error("ram acknowledge longer than one cycle");
	a_req_held: assert property (
		ram_req && !ram_ack |=> (ram_req || ram_ack) && $stable(ram_addr) &&
		$stable(ram_we) && $stable(ram_wdata))
		else $error("ram request changed before acknowledge");
	a_rsvd_reads_zero: assert property (
		ram_ack && !ram_we && (ram_addr == `RSVD_FIRST ||
		ram_addr == `RSVD_LAST) |-> ram_rdata == 8'h00)
		else $error("reserved byte read back nonzero");

	// ------
	// Regulator and pull-up
	// ------
	a_reg_off_mode: assert property (
		off_cond [*3] |-> reg_mode == REG_OFF)
		else $error("regulator not off");
	a_reg_standby_mode: assert property (
		(!off_cond && suspend_state) [*3] |-> reg_mode == REG_STANDBY)
		else $error("regulator not in standby while suspended");
	a_reg_active_mode: assert property (
		(!off_cond && !suspend_state) [*3] |-> reg_mode == REG_ACTIVE)
		else $error("regulator not active");
	a_pullup_off_clear: assert property (
		(!internal_pullup_enable) [*4] |-> !pullup_on)
		else $error("pull-up on while its enable is clear");
	a_pullup_needs_reg: assert property (
		(reg_mode == REG_OFF) [*4] |-> !pullup_on)
		else $error("pull-up on while regulator off");

	c_ram_write: cover property (ram_ack && ram_we);
	c_standby: cover property (reg_mode == REG_STANDBY);
	c_pullup: cover property ($rose(pullup_on));

endmodule : usb_bdt_link_props

// ### usb_bdt_ownership_pullup_ctrl_tb_top.sv
// Self-checking bench for the engine and controller ends joined by the link.
`timescale 1ns/1ps
`include "usb_bdt_consts.svh"

module usb_bdt_ownership_pullup_ctrl_tb_top;
	import usb_bdt_pkg::*;

	// ------
	// Signals and instances
	// ------
	logic        clk = 1'b0, rst_b = 1'b0;
	logic        tok_valid = 1'b0, tok_odd = 1'b0, suspend = 1'b0, vbus = 1'b0;
	logic [2:0]  tok_ep = 3'h0;
	logic [3:0]  tok_pid = 4'h0, wstrb = 4'h0;
	logic [6:0]  ep_en = 7'h7F;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, tok_ready, hs_valid;
	logic        dplus;
	logic [1:0]  bresp, rresp;
	handshake_t  hs;
	reg_mode_t   reg_mode;
	int          mismatches = 0, comparisons = 0;

	always #5 clk = ~clk;

	usb_bdt_link_if link_bus ();

	usb_bdt_engine u_usb_bdt_engine (.CLK(clk), .RST_B(rst_b),
		.TOKEN_VALID(tok_valid), .TOKEN_EP(tok_ep), .TOKEN_PID(tok_pid),
		.TOKEN_ODD(tok_odd), .EP_ENABLE(ep_en), .SUSPEND(suspend),
		.VBUS_SENSE(vbus), .TOKEN_READY(tok_ready),
		.HANDSHAKE_VALID(hs_valid), .HANDSHAKE(hs), .DPLUS_PULLUP(dplus),
		.REG_MODE(reg_mode), .link(link_bus));

	usb_bdt_controller u_usb_bdt_controller (.CLK(clk), .RST_B(rst_b),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .link(link_bus));

	usb_bdt_link_props props (.CLK(clk), .RST_B(rst_b),
		.ram_req(link_bus.ram_req), .ram_we(link_bus.ram_we),
		.ram_addr(link_bus.ram_addr), .ram_wdata(link_bus.ram_wdata),
		.ram_ack(link_bus.ram_ack), .ram_rdata(link_bus.ram_rdata),
		.internal_pullup_enable(link_bus.internal_pullup_enable),
		.regulator_enable(link_bus.regulator_enable),
		.stop_mode(link_bus.stop_mode),
		.suspend_state(link_bus.suspend_state),
		.reg_mode(link_bus.reg_mode), .pullup_on(link_bus.pullup_on));

	// ------
	// Bus and token tasks
	// ------
	task automatic final_report();
		if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report

	task automatic check(input string what, input logic [31:0] want,
		input logic [31:0] got);
		comparisons++;
		if (got !== want) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, want, got);
		end
	endtask : check

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic ram_op(input logic we, input logic [7:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(`REG_RAM_CMD, {15'h0, we, wd, a}, 4'hF, r);
		do axi_rd(`REG_RAM_DATA, d, r); while (d[`CMD_BUSY_BIT] !== 1'b0);
		rd = d[7:0];
	endtask : ram_op

	task automatic token(input logic [2:0] ep, input logic [3:0] pid,
		input logic odd, output handshake_t h, output int n);
		@(posedge clk);
		tok_ep <= ep; tok_pid <= pid; tok_odd <= odd; tok_valid <= 1'b1;
		do @(posedge clk); while (tok_ready !== 1'b1);
		tok_valid <= 1'b0;
		// Counts edges after the taking edge; 7 means no answer came.
		for (n = 1; n < 7; n++) begin
			@(posedge clk);
			if (hs_valid === 1'b1) break;
		end
		h = hs;
	endtask : token

	// ------
	// Scenarios
	// ------
	task automatic t_memory();
		logic [7:0]  a [5] = '{`RSVD_FIRST, `RSVD_LAST, `BUF_FIRST, 8'hFF,
			`BDT_LAST};
		logic [7:0]  b;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 5; i++) ram_op(1'b1, a[i], 8'hA0 + 8'(i), b);
		for (int i = 0; i < 5; i++) begin
			ram_op(1'b0, a[i], 8'h00, b);
			check("ram_byte", i < 2 ? 32'h0 : 32'hA0 + i, {24'h0, b});
		end
		axi_rd(8'h10, d, r);
		check("unmapped_read", {30'h0, `RESP_SLVERR}, {30'h0, r});
	endtask : t_memory

	task automatic t_descriptors();
		logic [7:0] b, st;
		logic [3:0] pid;
		logic [2:0] ep;
		handshake_t h;
		int         n;
		for (int s = 0; s < 10; s++) begin
			ep = 3'(s < 2 ? 0 : s < 6 ? s - 1 : s < 8 ? 5 : 6);
			pid = s == 1 ? `PID_SETUP : s[0] ? `PID_OUT : `PID_IN;
			st = {1'b1, s[0], 6'h00};
			ram_op(1'b1, 8'(s * 3), st, b);
			ram_op(1'b1, 8'(s * 3 + 1), 8'h5A, b);
			token(ep, pid, s >= 6 && s[0], h, n);
			check("ack", {30'h0, HS_ACK}, {30'h0, h});
			check("answer_delay", 32'd3, n);
			ram_op(1'b0, 8'(s * 3), 8'h00, b);
			check("status_back", {24'h0, 1'b0, s[0], pid, 2'b00}, {24'h0, b});
			ram_op(1'b0, 8'(s * 3 + 1), 8'h00, b);
			check("next_byte", 32'h5A, {24'h0, b});
		end
	endtask : t_descriptors

	task automatic t_owner();
		logic [7:0] s [2] = '{8'h44, 8'hC4};
		handshake_t w [2] = '{HS_NAK, HS_STALL};
		logic [7:0] b;
		handshake_t h;
		int         n;
		for (int i = 0; i < 2; i++) begin
			ram_op(1'b1, 8'h06, s[i], b);
			token(3'h1, `PID_OUT, 1'b0, h, n);
			check("refusal", {30'h0, w[i]}, {30'h0, h});
			ram_op(1'b0, 8'h06, 8'h00, b);
			check("untouched", {24'h0, s[i]}, {24'h0, b});
		end
		ep_en <= 7'h7D;
		token(3'h1, `PID_OUT, 1'b0, h, n);
		check("disabled_ep", 32'd7, n);
		ep_en <= 7'h7F;
		token(3'h7, `PID_OUT, 1'b0, h, n);
		check("absent_ep", 32'd7, n);
	endtask : t_owner

	task automatic t_regulator();
		logic [3:0]  c [6] = '{4'h0, 4'h2, 4'h6, 4'h6, 4'hA, 4'hE};
		logic        u [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		reg_mode_t   w [6] = '{REG_OFF, REG_ACTIVE, REG_STANDBY, REG_ACTIVE,
			REG_OFF, REG_OFF};
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 6; i++) begin
			suspend <= u[i];
			axi_wr(`REG_CTRL, {28'h0, c[i]}, 4'h1, r);
			repeat (4) @(posedge clk);
			check("reg_mode", {30'h0, w[i]}, {30'h0, reg_mode});
			axi_rd(`REG_STATUS, d, r);
			check("status_mode", {30'h0, w[i]}, {30'h0, d[1:0]});
			check("status_susp", {31'h0, u[i]}, {31'h0, d[2]});
		end
		suspend <= 1'b0;
	endtask : t_regulator

	task automatic t_pullup();
		logic [3:0] c [4] = '{4'h3, 4'h3, 4'h2, 4'h1};
		logic       w [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 4; i++) begin
			vbus <= i > 0;
			axi_wr(`REG_CTRL, {28'h0, c[i]}, 4'h1, r);
			repeat (6) @(posedge clk);
			check("pullup", {31'h0, w[i]}, {31'h0, dplus});
			axi_rd(`REG_STATUS, d, r);
			check("status_pullup", {31'h0, w[i]}, {31'h0, d[3]});
		end
	endtask : t_pullup

	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_memory();
		t_descriptors();
		t_owner();
		t_regulator();
		t_pullup();
		final_report();
	end

	initial begin
		#200000;
		mismatches++;
		final_report();
	end

endmodule : usb_bdt_ownership_pullup_ctrl_tb_top
